// file: conv_front_cfg.svh
// Register map, field positions, reset values for the converter front-end control.
// Assumes inclusion by bare name; definitions only.
`ifndef CONV_FRONT_CFG_SVH
`define CONV_FRONT_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define CHAN_SEL_ADDR       8'hBB
`define REF_CTRL_ADDR       8'hD1

// ****************************************
// Channel select field
// ****************************************
`define CHAN_CODE_MSB       5
`define CHAN_CODE_RESET     6'h3F
`define CHAN_LAST_PIN       6'h1F
`define CHAN_SMALL_LAST     6'h18
`define CHAN_RSVD_LAST      6'h2F
`define CHAN_TEMP           6'h30
`define CHAN_SUPPLY         6'h31

// ****************************************
// Reference control fields
// ****************************************
`define REF_LEVEL_BIT       4
`define REF_SOURCE_BIT      3
`define REF_TEMP_BIT        2
`define REF_BIAS_BIT        1
`define REF_BUF_BIT         0
`define REF_CTRL_RESET      5'h00

`endif

// file: conv_front_pkg.sv
// Types shared by the converter front-end control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package conv_front_pkg;

	// Kind of source on the converter positive input
	typedef enum logic [4:0] {
		route_pin      = 5'b00001,
		route_temp     = 5'b00010,
		route_supply   = 5'b00100,
		route_ground   = 5'b01000,
		route_none     = 5'b10000
	} route_e;

	typedef logic [5:0] chan_code_t;

endpackage

// file: converter_input_mux.sv
// Decoder from the positive channel code to a source kind and a one-hot pin select.
// Assumes the code comes from a register; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module converter_input_mux
	import conv_front_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire chan_code_t  positive_channel_code,
	output var  route_e      route_kind,
	output var  logic [31:0] pin_onehot
);
`include "conv_front_cfg.svh"

	// ****************************************
	// Source decode
	// ****************************************
	function automatic route_e decode_kind(input chan_code_t code);
		route_e k;
		k = route_ground;
		if (code <= `CHAN_LAST_PIN) begin
			// Upper port 3 pins exist only on larger packages
			if (!LARGE_PACKAGE && code > `CHAN_SMALL_LAST)
				k = route_none;
			else
				k = route_pin;
		end else if (code <= `CHAN_RSVD_LAST) begin
			k = route_none;
		end else if (code == `CHAN_TEMP) begin
			k = route_temp;
		end else if (code == `CHAN_SUPPLY) begin
			k = route_supply;
		end
		return k;
	endfunction

	// Kind and pin select
	always_comb begin
		route_kind = decode_kind(positive_channel_code);
		pin_onehot = 32'h0000_0000;
		if (route_kind == route_pin)
			pin_onehot[positive_channel_code[4:0]] = 1'b1;
	end

endmodule // converter_input_mux

`default_nettype wire

// file: adc_input_and_reference_select.sv
// Special function registers and control lines for the converter's input mux,
// reference select, temperature sensor, bias generator and reference buffer.
// Assumes a synchronous SFR bus; read data is returned the cycle after the read strobe.
//
// How it works
// - Channel select upper two bits read zero
// - Six-bit code picks port pins 0 to 31
// - Port 3 bits 1-7 only on large packages
// - Codes 32 to 47 reserved, nothing connected
// - 48 temp sensor, 49 supply, rest ground
// - Temp sensor powered only while enabled
// - Reference select: 0 pin, 1 supply
// - Bias on automatically or by manual bit
// - Bias request: converter, sensor, oscillator, manual
// - Reference buffer drives pin only when enabled
// - Level select picks low or high level
// - Reference control bits 4..0, reset zero
// - Level select 0 low, 1 high
`timescale 1ns/1ps
`default_nettype none

module adc_input_and_reference_select
	import conv_front_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr_en,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd_en,
	output var  logic [7:0]  sfr_rdata,
	input  wire logic        converter_enable,
	input  wire logic        oscillator_enable,
	output var  logic [31:0] pin_route,
	output var  logic        temp_route,
	output var  logic        supply_route,
	output var  logic        ground_route,
	output var  logic        reserved_route,
	output var  logic        temp_sensor_power,
	output var  logic        reference_from_supply,
	output var  logic        bias_generator_on,
	output var  logic        reference_buffer_drive,
	output var  logic        reference_level_high
);
`include "conv_front_cfg.svh"

	// ****************************************
	// Register state
	// ****************************************
	chan_code_t  converter_positive_input_select_reg, chan_next;
	logic [4:0]  reference_control_reg, ref_next;
	logic [7:0]  rdata_reg, rdata_next;
	route_e      route_kind;
	logic [31:0] pin_onehot;

	// Register writes and read mux
	always_comb begin
		chan_next  = converter_positive_input_select_reg;
		ref_next   = reference_control_reg;
		rdata_next = rdata_reg;
		if (sfr_wr_en && sfr_addr == `CHAN_SEL_ADDR)
			chan_next = sfr_wdata[`CHAN_CODE_MSB:0];
		if (sfr_wr_en && sfr_addr == `REF_CTRL_ADDR)
			ref_next = sfr_wdata[4:0];
		if (sfr_rd_en) begin
			unique case (sfr_addr)
				`CHAN_SEL_ADDR: rdata_next = {2'b00, converter_positive_input_select_reg};
				`REF_CTRL_ADDR: rdata_next = {3'b000, reference_control_reg};
				default:        rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			converter_positive_input_select_reg <= `CHAN_CODE_RESET;
			reference_control_reg               <= `REF_CTRL_RESET;
			rdata_reg                           <= 8'h00;
		end else begin
			converter_positive_input_select_reg <= chan_next;
			reference_control_reg               <= ref_next;
			rdata_reg                           <= rdata_next;
		end
	end

	assign sfr_rdata = rdata_reg;

	// ****************************************
	// Channel decode
	// ****************************************
	converter_input_mux #(
		.LARGE_PACKAGE (LARGE_PACKAGE)
	) i_converter_input_mux (
		.positive_channel_code (converter_positive_input_select_reg),
		.route_kind            (route_kind),
		.pin_onehot            (pin_onehot)
	);

	// ****************************************
	// Analog control lines
	// ****************************************
	logic [31:0] pin_next;
	logic [3:0]  kind_next;
	logic [4:0]  ctl_next;
	logic [3:0]  kind_reg;
	logic [4:0]  ctl_reg;
	logic [31:0] pin_reg;

	// Next values of routed source and analog enables
	always_comb begin
		pin_next  = pin_onehot;
		kind_next = {route_kind == route_none, route_kind == route_ground,
			route_kind == route_supply, route_kind == route_temp};
		ctl_next[0] = reference_control_reg[`REF_TEMP_BIT];
		ctl_next[1] = reference_control_reg[`REF_SOURCE_BIT];
		ctl_next[2] = reference_control_reg[`REF_BIAS_BIT] | converter_enable
			| reference_control_reg[`REF_TEMP_BIT] | oscillator_enable;
		ctl_next[3] = reference_control_reg[`REF_BUF_BIT];
		ctl_next[4] = reference_control_reg[`REF_LEVEL_BIT];
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_reg  <= 32'h0000_0000;
			kind_reg <= 4'h0;
			ctl_reg  <= 5'h00;
		end else begin
			pin_reg  <= pin_next;
			kind_reg <= kind_next;
			ctl_reg  <= ctl_next;
		end
	end

	assign pin_route              = pin_reg;
	assign temp_route             = kind_reg[0];
	assign supply_route           = kind_reg[1];
	assign ground_route           = kind_reg[2];
	assign reserved_route         = kind_reg[3];
	assign temp_sensor_power      = ctl_reg[0];
	assign reference_from_supply  = ctl_reg[1];
	assign bias_generator_on      = ctl_reg[2];
	assign reference_buffer_drive = ctl_reg[3];
	assign reference_level_high   = ctl_reg[4];

	// ****************************************
	// Checks
	// ****************************************
	property p_chan_read_upper_zero;
		@(posedge ref_clk) disable iff (reset)
		(sfr_rd_en && sfr_addr == `CHAN_SEL_ADDR) |=>
			(sfr_rdata == {2'h0, $past(converter_positive_input_select_reg)});
	endproperty
	a_chan_read_upper_zero: assert property (p_chan_read_upper_zero)
		else $error("channel select upper bits not zero");

	property p_pin_route;
		@(posedge ref_clk) disable iff (reset)
		(converter_positive_input_select_reg < 6'h19) |=>
			(pin_route == (32'h1 << $past(converter_positive_input_select_reg[4:0])));
	endproperty
	a_pin_route: assert property (p_pin_route)
		else $error("pin route does not follow channel code");

	property p_small_pkg;
		@(posedge ref_clk) disable iff (reset)
		(!LARGE_PACKAGE && converter_positive_input_select_reg inside {[6'h19:6'h1F]})
			|=> (pin_route == 32'h0 && reserved_route);
	endproperty
	a_small_pkg: assert property (p_small_pkg)
		else $error("missing pin routed on small package");

	property p_reserved;
		@(posedge ref_clk) disable iff (reset)
		(converter_positive_input_select_reg inside {[6'h20:6'h2F]}) |=>
			(reserved_route && !temp_route && !supply_route && !ground_route && pin_route == 32'h0);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved code connected a source");

	property p_special;
		@(posedge ref_clk) disable iff (reset)
		// Outputs are cleared during reset, so start only from a sampled run cycle
		!reset |=> (temp_route == ($past(converter_positive_input_select_reg) == 6'h30))
			&& (supply_route == ($past(converter_positive_input_select_reg) == 6'h31))
			&& (ground_route == ($past(converter_positive_input_select_reg) >= 6'h32));
	endproperty
	a_special: assert property (p_special)
		else $error("special source decode wrong");

	property p_reset_ground;
		@(posedge ref_clk) $fell(reset) |-> (converter_positive_input_select_reg == 6'h3F) ##1 ground_route;
	endproperty
	a_reset_ground: assert property (p_reset_ground)
		else $error("ground not selected after reset");

	property p_bias;
		@(posedge ref_clk) disable iff (reset)
		(converter_enable || oscillator_enable || reference_control_reg[1] || reference_control_reg[2])
			|=> bias_generator_on;
	endproperty
	a_bias: assert property (p_bias)
		else $error("bias generator not requested");

	property p_no_bias;
		@(posedge ref_clk) disable iff (reset)
		!(converter_enable || oscillator_enable || reference_control_reg[1] || reference_control_reg[2])
			|=> !bias_generator_on;
	endproperty
	a_no_bias: assert property (p_no_bias)
		else $error("bias generator on without request");

	property p_ref_write;
		@(posedge ref_clk) disable iff (reset)
		(sfr_wr_en && sfr_addr == `REF_CTRL_ADDR) |=> ##1
			(temp_sensor_power == $past(sfr_wdata[2], 2)) && (reference_from_supply == $past(sfr_wdata[3], 2))
			&& (reference_buffer_drive == $past(sfr_wdata[0], 2))
			&& (reference_level_high == $past(sfr_wdata[4], 2));
	endproperty
	a_ref_write: assert property (p_ref_write)
		else $error("reference control outputs do not follow write");

endmodule // adc_input_and_reference_select

`default_nettype wire

// file: adc_input_and_reference_select_bench.sv
// Self-checking bench for the converter front-end control registers and lines.
// Assumes the design files and conv_front_cfg.svh are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "conv_front_cfg.svh"

module adc_input_and_reference_select_bench
	import conv_front_pkg::*;
;
	logic        ref_clk;
	logic        reset;
	logic [7:0]  sfr_addr;
	logic        sfr_wr_en;
	logic [7:0]  sfr_wdata;
	logic        sfr_rd_en;
	logic [7:0]  sfr_rdata;
	logic        converter_enable;
	logic        oscillator_enable;
	logic [31:0] pin_route;
	logic        temp_route;
	logic        supply_route;
	logic        ground_route;
	logic        reserved_route;
	logic        temp_sensor_power;
	logic        reference_from_supply;
	logic        bias_generator_on;
	logic        reference_buffer_drive;
	logic        reference_level_high;
	logic [40:0] out_vec;
	logic [31:0] small_pin_route;
	logic        small_reserved_route;
	int          n_errors;
	int          total_checks;

	// ****************************************
	// Design and clock
	// ****************************************
	adc_input_and_reference_select i_adc_input_and_reference_select (
		.ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
		.sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata),
		.converter_enable(converter_enable), .oscillator_enable(oscillator_enable),
		.pin_route(pin_route), .temp_route(temp_route), .supply_route(supply_route),
		.ground_route(ground_route), .reserved_route(reserved_route),
		.temp_sensor_power(temp_sensor_power), .reference_from_supply(reference_from_supply),
		.bias_generator_on(bias_generator_on), .reference_buffer_drive(reference_buffer_drive),
		.reference_level_high(reference_level_high)
	);

	// Small-package variant on the same register traffic
	adc_input_and_reference_select #(
		.LARGE_PACKAGE(1'b0)
	) i_adc_input_and_reference_select_small (
		.ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
		.sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(),
		.converter_enable(converter_enable), .oscillator_enable(oscillator_enable),
		.pin_route(small_pin_route), .temp_route(), .supply_route(), .ground_route(),
		.reserved_route(small_reserved_route), .temp_sensor_power(),
		.reference_from_supply(), .bias_generator_on(), .reference_buffer_drive(),
		.reference_level_high()
	);

	// Outputs gathered in one vector for comparison
	assign out_vec = {pin_route, temp_route, supply_route, ground_route, reserved_route,
		reference_level_high, reference_from_supply, temp_sensor_power,
		bias_generator_on, reference_buffer_drive};

	// 100 ns clock
	always #50 ref_clk = ~ref_clk;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic out_chk(input logic [40:0] exp);
		total_checks++;
		if (out_vec !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, out_vec, exp);
		end
	endtask

	// Small package: upper port 3 codes connect nothing, others as large
	task automatic small_chk(input logic [5:0] c);
		logic [40:0] e;
		logic [32:0] x;
		e = exp_out(c, 5'h00, 1'h0, 1'h0);
		x = (c > 6'h18 && c < 6'h20) ? {1'h1, 32'h0} : {e[5], e[40:9]};
		total_checks++;
		if ({small_reserved_route, small_pin_route} !== x) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, {small_reserved_route, small_pin_route}, x);
		end
	endtask

	// One write strobe, taken at the second edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr_en <= 1'h1;
		@(posedge ref_clk);
		sfr_wr_en <= 1'h0;
	endtask

	// One read strobe, data checked a cycle after it is taken
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		sfr_addr  <= a;
		sfr_rd_en <= 1'h1;
		@(posedge ref_clk);
		sfr_rd_en <= 1'h0;
		@(posedge ref_clk);
		#1;
		chk8(sfr_rdata, exp);
	endtask

	// Control outputs follow two edges after a change
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	// Expected outputs from channel code, reference bits and bias requests
	function automatic logic [40:0] exp_out(input logic [5:0] c, input logic [4:0] r,
		input logic cv, input logic os);
		logic [31:0] p;
		logic [3:0]  k;
		p = 32'h0;
		k = 4'h0;
		if (c <= 6'h1F) p[c[4:0]] = 1'h1;
		else if (c <= 6'h2F) k = 4'h1;
		else if (c == 6'h30) k = 4'h8;
		else if (c == 6'h31) k = 4'h4;
		else k = 4'h2;
		return {p, k, r[4:2], r[1] | r[2] | cv | os, r[0]};
	endfunction

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		#1000000;
		n_errors++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
		stop_test;
	end

	initial begin
		ref_clk = 1'h0;
		reset = 1'h1;
		sfr_addr = 8'h00;
		sfr_wr_en = 1'h0;
		sfr_wdata = 8'h00;
		sfr_rd_en = 1'h0;
		converter_enable = 1'h0;
		oscillator_enable = 1'h0;
		n_errors = 0;
		total_checks = 0;
		repeat (12) @(posedge ref_clk);
		reset <= 1'h0;
		// Reset values and an unmapped read
		rd_chk(8'hBB, 8'h3F);
		rd_chk(8'hD1, 8'h00);
		rd_chk(8'h00, 8'h00);
		out_chk(exp_out(6'h3F, 5'h00, 1'h0, 1'h0));
		// Every channel code, upper bits written as ones
		for (int c = 0; c < 64; c++) begin
			wr(8'hBB, {2'h3, 6'(c)});
			rd_chk(8'hBB, {2'h0, 6'(c)});
			settle;
			out_chk(exp_out(6'(c), 5'h00, 1'h0, 1'h0));
			small_chk(6'(c));
		end
		// Each reference control bit alone, bits 7:5 written as ones
		for (int i = 0; i < 5; i++) begin
			wr(8'hD1, 8'hE0 | (8'h01 << i));
			rd_chk(8'hD1, 8'h01 << i);
			settle;
			out_chk(exp_out(6'h3F, 5'(1 << i), 1'h0, 1'h0));
		end
		// Automatic bias requests from converter and oscillator
		wr(8'hD1, 8'h00);
		for (int j = 0; j < 4; j++) begin
			@(posedge ref_clk);
			converter_enable  <= j[0];
			oscillator_enable <= j[1];
			settle;
			out_chk(exp_out(6'h3F, 5'h00, j[0], j[1]));
		end
		// Writes to neighbouring addresses leave both registers alone
		wr(8'hBA, 8'h30);
		wr(8'hD0, 8'h1F);
		rd_chk(8'hBB, 8'h3F);
		rd_chk(8'hD1, 8'h00);
		// Second reset in mid-run restores defaults
		wr(8'hBB, 8'h30);
		wr(8'hD1, 8'h1F);
		@(posedge ref_clk);
		reset <= 1'h1;
		converter_enable  <= 1'h0;
		oscillator_enable <= 1'h0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		rd_chk(8'hBB, 8'h3F);
		rd_chk(8'hD1, 8'h00);
		out_chk(exp_out(6'h3F, 5'h00, 1'h0, 1'h0));
		stop_test;
	end
endmodule // adc_input_and_reference_select_bench

`default_nettype wire
